// [design/agt_offs_map.sv]
/*
  agt_offs_map: turns magnitude and sign into a signed offset in microvolts,
  about 176 uV per step, 45 mV at full code.
  Assumes: inputs from registers on the same clock.
*/
`timescale 1ns/1ns
module agt_offs_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] magnitude,
  input wire logic negative,
  output logic signed [16:0] offset_uv
);
  logic [23:0] prod;
  logic [15:0] mag_uv;
  logic signed [16:0] offset_uv_next;

  assign prod = 24'(magnitude) * 24'(agt_pkg::AGT_OFFS_FULL_UV);
  assign mag_uv = 16'(prod / 24'(agt_pkg::AGT_OFFS_CODES));
  assign offset_uv_next = negative ? -$signed({1'b0, mag_uv}) : $signed({1'b0, mag_uv});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      offset_uv <= 17'sh00000;
    end else begin
      offset_uv <= offset_uv_next;
    end
  end
endmodule : agt_offs_map

// [design/agt_span_map.sv]
/*
  agt_span_map: turns the 9-bit span code into a nominal span in mV, linear and
  monotonic from 560 to 840, plus a flag for codes outside the advised band.
  Assumes: code comes from a register on the same clock.
*/
`timescale 1ns/1ns
module agt_span_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [8:0] code,
  output logic [9:0] span_mv,
  output logic out_of_band
);
  logic [18:0] scaled;
  logic [9:0] span_mv_next;
  logic band_next;

  assign scaled = 19'(code) * 19'(agt_pkg::AGT_SPAN_RANGE_MV);
  assign span_mv_next = 10'(agt_pkg::AGT_SPAN_MIN_MV)
                      + 10'(scaled / 19'(agt_pkg::AGT_SPAN_CODES));
  // advisory only: host may still write anything
  assign band_next = (code < agt_pkg::AGT_SPAN_REC_LO) || (code > agt_pkg::AGT_SPAN_REC_HI);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_mv <= 10'h2BC;
      out_of_band <= 1'b0;
    end else begin
      span_mv <= span_mv_next;
      out_of_band <= band_next;
    end
  end
endmodule : agt_span_map

// [design/agt_trim_regs.sv]
/*
  agt_trim_regs: APB slave holding the write-only span trim and offset trim words
  of a dual converter, driving the trim codes out to the analog side.
  Assumes: APB3 master on pclk; the analog paths consume the trim outputs;
  calibration logic lives elsewhere and is not touched by trim writes.
*/
// Function
// - span trim at index 3, write-only, resets 807F
// - span bits 15..7 form unsigned 9-bit code
// - span code maps linearly to 560..840 mV
// - span code resets to no adjustment
// - span write applies without recalibration
// - offset trim at index A, write-only, resets 007F
// - offset bits 15..8 are linear magnitude
// - bit 7 sets offset sign, resets positive
// - offset magnitude resets to zero
`timescale 1ns/1ns
module agt_trim_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [8:0] span_code,
  output logic [7:0] offs_magnitude,
  output logic offs_negative,
  output logic [9:0] span_mv,
  output logic signed [16:0] offs_uv,
  output logic span_out_of_band,
  output logic trim_update
);
  logic [15:0] span_reg;
  logic [15:0] span_next;
  logic [15:0] offs_reg;
  logic [15:0] offs_next;
  logic [1:0] fill_err_reg;
  logic [1:0] fill_err_next;
  logic [31:0] prdata_next;
  logic pslverr_next;
  logic trim_update_next;
  agt_pkg::agt_phase_t phase_reg;
  agt_pkg::agt_phase_t phase_next;

  wire setup_cyc = psel && !penable;
  wire access_cyc = psel && penable;
  // only an access that follows its own setup counts; a stuck penable writes nothing
  wire in_access = access_cyc && (phase_reg == agt_pkg::AGT_SETUP);
  wire hit_span = (paddr == agt_pkg::AGT_SPAN_ADDR);
  wire hit_offs = (paddr == agt_pkg::AGT_OFFS_ADDR);
  wire hit_stat = (paddr == agt_pkg::AGT_STAT_ADDR);
  wire mapped = hit_span || hit_offs || hit_stat;
  wire wr_take = in_access && pwrite;
  wire wr_span = wr_take && hit_span;
  wire wr_offs = wr_take && hit_offs;

  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old_word,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [15:0] res;
    res = old_word;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : merge_lanes

  function automatic logic fill_bad(input logic [15:0] word);
    return word[6:0] != agt_pkg::AGT_FILL_ONES;
  endfunction : fill_bad

  // writes land straight in the live trim word; nothing sequences a recal
  assign span_next = wr_span ? merge_lanes(span_reg, pwdata, pstrb) : span_reg;
  assign offs_next = wr_offs ? merge_lanes(offs_reg, pwdata, pstrb) : offs_reg;

  // sticky note of a write that broke the must-be-ones fill; status only
  assign fill_err_next = {
    fill_err_reg[1] || (wr_offs && fill_bad(offs_next)),
    fill_err_reg[0] || (wr_span && fill_bad(span_next))
  };

  // write-only words read as zero; only the status word shows state
  // loaded at the setup edge so the answer stands while pready is sampled
  assign prdata_next = (setup_cyc && !pwrite && hit_stat)
                     ? {14'h0000, fill_err_reg, 16'h0000}
                     : 32'h0000_0000;
  assign pslverr_next = setup_cyc && !mapped;
  assign trim_update_next = wr_span || wr_offs;

  always_comb begin
    phase_next = phase_reg;
    case (phase_reg)
      agt_pkg::AGT_IDLE: begin
        if (setup_cyc) begin
          phase_next = agt_pkg::AGT_SETUP;
        end
      end
      agt_pkg::AGT_SETUP: begin
        phase_next = access_cyc ? agt_pkg::AGT_ACCESS : agt_pkg::AGT_IDLE;
      end
      agt_pkg::AGT_ACCESS: begin
        phase_next = setup_cyc ? agt_pkg::AGT_SETUP : agt_pkg::AGT_IDLE;
      end
      default: begin
        phase_next = agt_pkg::AGT_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_reg <= agt_pkg::AGT_SPAN_RST;
      offs_reg <= agt_pkg::AGT_OFFS_RST;
      fill_err_reg <= 2'h0;
      phase_reg <= agt_pkg::AGT_IDLE;
    end else begin
      span_reg <= span_next;
      offs_reg <= offs_next;
      fill_err_reg <= fill_err_next;
      phase_reg <= phase_next;
    end
  end

  // zero wait states: pready registered high from reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b1;
      pslverr <= 1'b0;
      trim_update <= 1'b0;
    end else begin
      prdata <= prdata_next;
      pready <= 1'b1;
      pslverr <= pslverr_next;
      trim_update <= trim_update_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      span_code <= agt_pkg::AGT_SPAN_NOADJ;
      offs_magnitude <= 8'h00;
      offs_negative <= 1'b0;
    end else begin
      span_code <= span_next[agt_pkg::AGT_SPAN_MSB:agt_pkg::AGT_SPAN_LSB];
      offs_magnitude <= offs_next[agt_pkg::AGT_OFFS_MSB:agt_pkg::AGT_OFFS_LSB];
      offs_negative <= offs_next[agt_pkg::AGT_SIGN_BIT];
    end
  end

  agt_span_map u_span_map (
    .pclk(pclk),
    .presetn(presetn),
    .code(span_reg[agt_pkg::AGT_SPAN_MSB:agt_pkg::AGT_SPAN_LSB]),
    .span_mv(span_mv),
    .out_of_band(span_out_of_band)
  );

  agt_offs_map u_offs_map (
    .pclk(pclk),
    .presetn(presetn),
    .magnitude(offs_reg[agt_pkg::AGT_OFFS_MSB:agt_pkg::AGT_OFFS_LSB]),
    .negative(offs_reg[agt_pkg::AGT_SIGN_BIT]),
    .offset_uv(offs_uv)
  );
endmodule : agt_trim_regs

// [shared/agt_pkg.sv]
/*
  agt_pkg: register indices, reset words, field positions and trim-scale constants
  for the span and offset trim bank.
  Assumes: used by qualified name only; no import anywhere.
*/
package agt_pkg;
  // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
  localparam logic [3:0] AGT_SPAN_IDX = 4'h3;
  localparam logic [3:0] AGT_OFFS_IDX = 4'hA;
  localparam logic [11:0] AGT_SPAN_ADDR = 12'h00C;
  localparam logic [11:0] AGT_OFFS_ADDR = 12'h028;
  localparam logic [11:0] AGT_STAT_ADDR = 12'h040;
  localparam logic [15:0] AGT_SPAN_RST = 16'h807F;
  localparam logic [15:0] AGT_OFFS_RST = 16'h007F;
  localparam int AGT_SPAN_MSB = 15;
  localparam int AGT_SPAN_LSB = 7;
  localparam int AGT_OFFS_MSB = 15;
  localparam int AGT_OFFS_LSB = 8;
  localparam int AGT_SIGN_BIT = 7;
  localparam logic [6:0] AGT_FILL_ONES = 7'h7F;
  localparam logic [8:0] AGT_SPAN_NOADJ = 9'h100;
  localparam logic [8:0] AGT_SPAN_REC_LO = 9'h0C0;
  localparam logic [8:0] AGT_SPAN_REC_HI = 9'h1C0;
  // span in mV: 560 + code * 280 / 511, offset about 45 mV full code
  localparam int AGT_SPAN_MIN_MV = 560;
  localparam int AGT_SPAN_RANGE_MV = 280;
  localparam int AGT_SPAN_CODES = 511;
  localparam int AGT_OFFS_FULL_UV = 45000;
  localparam int AGT_OFFS_CODES = 255;
  localparam logic [31:0] AGT_SLVERR_NONE = 32'h0000_0000;

  typedef enum logic [2:0] {
    AGT_IDLE = 3'b001,
    AGT_SETUP = 3'b010,
    AGT_ACCESS = 3'b100
  } agt_phase_t;
endpackage : agt_pkg

// [sim/agt_trim_assertions.sv]
/* agt_trim_assertions: port-level checks of the span/offset trim bank.
   Assumes: bound to agt_trim_regs; outputs register at the access edge. */
`timescale 1ns/1ns
module agt_trim_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic [8:0] span_code,
  input wire logic [7:0] offs_magnitude,
  input wire logic offs_negative,
  input wire logic trim_update
);
  wire logic wr = psel && penable && pwrite;
  wire logic rd = psel && penable && !pwrite;
  wire logic hit_s = paddr == agt_pkg::AGT_SPAN_ADDR;
  wire logic hit_o = paddr == agt_pkg::AGT_OFFS_ADDR;
  wire logic full = pstrb[1:0] == 2'h3;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr_span; wr && hit_s && full; endsequence
  sequence s_wr_offs; wr && hit_o && full; endsequence
  a_span_load: assert property (s_wr_span |=> span_code == $past(pwdata[15:7]))
    else $error("span code not loaded");
  a_offs_load: assert property (s_wr_offs |=> offs_magnitude == $past(pwdata[15:8]))
    else $error("offset magnitude not loaded");
  a_sign_load: assert property (s_wr_offs |=> offs_negative == $past(pwdata[7]))
    else $error("offset sign not loaded");
  a_span_hold: assert property (!(wr && hit_s) |=> $stable(span_code))
    else $error("span code moved without write");
  a_offs_hold: assert property (!(wr && hit_o) |=> $stable({offs_magnitude, offs_negative}))
    else $error("offset moved without write");
  a_write_pulse: assert property ((s_wr_span or s_wr_offs) |=> trim_update)
    else $error("no update pulse after trim write");
  a_pulse_cause: assert property (trim_update |-> $past(wr && (hit_s || hit_o)))
    else $error("update pulse without trim write");
  a_read_blank: assert property (rd && (hit_s || hit_o) |-> prdata == 32'h0000_0000)
    else $error("trim word readable");
endmodule : agt_trim_assertions

// [sim/tb_top.sv]
/* tb_top: APB bench for agt_trim_regs: reset values, loads, reads, errors.
   Assumes: zero-wait slave; read data and pslverr stand in the access phase. */
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, offs_negative, span_out_of_band, trim_update, slverr, b;
  logic [8:0] span_code, c;
  logic [7:0] offs_magnitude;
  logic [9:0] span_mv;
  logic signed [16:0] offs_uv;
  logic [15:0] sw [5] = '{16'h007F, 16'hFFFF, 16'h807F, 16'hE07F, 16'h5FFF};
  logic [9:0] mv [3] = '{10'h230, 10'h348, 10'h2BC};
  int err_count = 0, compares = 0;
  always #4 pclk = ~pclk;
  agt_trim_regs u_agt_trim_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .span_code, .offs_magnitude,
    .offs_negative, .span_mv, .offs_uv, .span_out_of_band, .trim_update);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hF);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    // read before the edge's updates land: these are the access-phase values
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic finish_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    err_count++;
    finish_test();
  end
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK("span_code", 9'h100, span_code)
    `CHK("span_mv", 10'h2BC, span_mv)
    `CHK("offs_mag", 8'h00, offs_magnitude)
    `CHK("offs_neg", 1'h0, offs_negative)
    `CHK("offs_uv", 17'sh00000, offs_uv)
    foreach (sw[i]) begin
      c = sw[i][15:7];
      b = c < agt_pkg::AGT_SPAN_REC_LO || c > agt_pkg::AGT_SPAN_REC_HI;
      apb(1'b1, agt_pkg::AGT_SPAN_ADDR, {16'h0000, sw[i]});
      `CHK("span_code", c, span_code)
      `CHK("trim_update", 1'h1, trim_update)
      @(posedge pclk);
      #1;
      `CHK("trim_update", 1'h0, trim_update)
      if (i < 3) `CHK("span_mv", mv[i], span_mv)
      `CHK("band", b, span_out_of_band)
    end
    apb(1'b1, agt_pkg::AGT_OFFS_ADDR, 32'h0000_FFFF);
    `CHK("offs_mag", 8'hFF, offs_magnitude)
    `CHK("offs_neg", 1'h1, offs_negative)
    @(posedge pclk);
    #1;
    `CHK("offs_uv", -17'shAFC8, offs_uv)
    apb(1'b1, agt_pkg::AGT_OFFS_ADDR, 32'h0000_127F);
    `CHK("offs_mag", 8'h12, offs_magnitude)
    `CHK("offs_neg", 1'h0, offs_negative)
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, k ? agt_pkg::AGT_OFFS_ADDR : agt_pkg::AGT_SPAN_ADDR, 32'h0000_0000);
      `CHK("trim_read", 32'h0000_0000, rd)
      `CHK("pslverr", 1'h0, slverr)
    end
    apb(1'b1, 12'h010, 32'h0000_007F);
    `CHK("pslverr", 1'h1, slverr)
    `CHK("span_code", 9'hBF, span_code)
    apb(1'b1, agt_pkg::AGT_SPAN_ADDR, 32'h0000_8000);
    apb(1'b0, agt_pkg::AGT_STAT_ADDR, 32'h0000_0000);
    `CHK("fill_flag", 1'h1, rd[16])
    `CHK("fill_flag", 1'h0, rd[17])
    // upper lane only: low byte of the stored word must survive
    apb(1'b1, agt_pkg::AGT_SPAN_ADDR, 32'h0000_3300, 4'h2);
    `CHK("span_code", 9'h066, span_code)
    // mid-run reset: both trims fall back to their power-on words
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK("span_code", 9'h100, span_code)
    `CHK("offs_mag", 8'h00, offs_magnitude)
    finish_test();
  end
endmodule : tb_top
bind agt_trim_regs agt_trim_assertions u_agt_trim_assertions (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .span_code, .offs_magnitude,
  .offs_negative, .trim_update);
